// >>> mask_status_pkg.sv
// Constants for the alert/fault mask and status register bank.
// Assumes a single 10 MHz clock domain and a two-wire management port.
package mask_status_pkg;

  localparam logic [6:0] DEV_ADDR = 7'h20;
  localparam logic [7:0] ALERT_MASK_OFS = 8'hF9;
  localparam logic [7:0] FAULT_MASK_OFS = 8'hFA;
  localparam logic [7:0] GEN_STATUS_OFS = 8'hFB;
  localparam logic [7:0] PHASE_STATUS_OFS = 8'hFC;

  localparam logic [7:0] ALERT_MASK_RST = 8'h00;
  localparam logic [7:0] FAULT_MASK_RST = 8'h00;
  localparam logic [7:0] GEN_STATUS_RST = 8'h00;
  localparam logic [7:0] PHASE_STATUS_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  localparam int VOUT_BIT = 7;
  localparam int IOUT_BIT = 6;
  localparam int COMM_BIT = 3;
  localparam int MON_BIT = 2;
  localparam int PWR_BIT = 0;
  localparam logic [7:0] SRC_USED = 8'hCD;

  localparam int GS_FAULT_BIT = 7;
  localparam int GS_ALERT_BIT = 6;
  localparam int GS_READY_BIT = 4;
  localparam int PS_PHASE4_BIT = 5;
  localparam int PS_PHASE3_BIT = 4;
  localparam int PS_PHASE2_BIT = 3;
  localparam int PS_SAVE_BIT = 2;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_CMD = 4'h2,
    ST_CMD_ACK = 4'h6,
    ST_WDATA = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA = 4'h4,
    ST_RDATA_ACK = 4'hC
  } link_state_type;

endpackage

// >>> mask_combine_if.sv
// Carrier between the register front end and the mask combiner.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface mask_combine_if;
  logic [7:0] alert_mask;
  logic [7:0] fault_mask;
  logic [7:0] src;
  logic fault;
  logic alert;
  modport regs (output alert_mask, output fault_mask, output src, input fault, input alert);
  modport comb (input alert_mask, input fault_mask, input src, output fault, output alert);
endinterface
`default_nettype wire

// >>> mask_combine.sv
// Gates status categories with the two masks into fault and alert levels.
// Assumes source flags arrive synchronous to clk, already placed at mask bit positions.
`timescale 1ns/1ps
`default_nettype none
module mask_combine
  import mask_status_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  mask_combine_if.comb mc
);

  logic [7:0] fault_hit;
  logic [7:0] alert_hit;

  // Reserved positions never contribute, whatever the mask holds
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      assign fault_hit[gi] = SRC_USED[gi] & mc.src[gi] & ~mc.fault_mask[gi];
      assign alert_hit[gi] = SRC_USED[gi] & mc.src[gi] & ~mc.alert_mask[gi];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mc.fault <= 1'b0;
    end else begin
      mc.fault <= |fault_hit;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mc.alert <= 1'b0;
    end else begin
      mc.alert <= |alert_hit;
    end
  end

  vout_alert_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mc.alert_mask[7] && mc.src == 8'h80) |=> !mc.alert)
    else $error("masked output-voltage source raised alert");
  comm_alert_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mc.alert_mask[3] && mc.src == 8'h08) |=> !mc.alert)
    else $error("masked comm source raised alert");
  mon_alert_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mc.alert_mask[2] && mc.src == 8'h04) |=> !mc.alert)
    else $error("masked monitor source raised alert");
  power_alert_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mc.alert_mask[0] && mc.src == 8'h01) |=> !mc.alert)
    else $error("masked power source raised alert");
  vout_fault_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mc.fault_mask[7] && mc.src == 8'h80) |=> !mc.fault)
    else $error("masked output-voltage source raised fault");
  iout_fault_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mc.fault_mask[6] && mc.src == 8'h40) |=> !mc.fault)
    else $error("masked output-current source raised fault");
  comm_fault_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mc.fault_mask[3] && mc.src == 8'h08) |=> !mc.fault)
    else $error("masked comm source raised fault");
  power_fault_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mc.fault_mask[0] && mc.src == 8'h01) |=> !mc.fault)
    else $error("masked power source raised fault");
  unmasked_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && (|(mc.src & ~mc.fault_mask & SRC_USED))) |=> mc.fault)
    else $error("unmasked source did not raise fault");
  reserved_src_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((mc.src & SRC_USED) == 8'h00) |=> (!mc.fault && !mc.alert))
    else $error("reserved position raised an indication");

  fault_seen_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(mc.fault));
  alert_only_c: cover property (@(posedge clk) disable iff (!rst_n) mc.alert && !mc.fault);

endmodule
`default_nettype wire

// >>> mask_status_regs.sv
// Two-wire management slave holding the alert/fault masks and status readback.
// Assumes open-drain data and clock pins resolved outside; status flags come from
// same-clock logic, pins and the power-save input are asynchronous.
//
// Function
// - A set alert mask bit 7 stops output-voltage status from raising alert.
// - A set alert mask bit 3 stops communication status from raising alert.
// - A set alert mask bit 2 stops monitor input limit crossings from raising alert.
// - A set alert mask bit 0 stops output power over limit from raising alert.
// - The fault mask is an eight-bit read/write register that resets to zero.
// - A set fault mask bit 7 stops output-voltage status from raising fault.
// - A set fault mask bit 6 stops output-current status from raising fault.
// - A set fault mask bit 3 stops communication status from raising fault.
// - A set fault mask bit 0 stops output power over limit from raising fault.
// - General status is read-only, resets to zero, with fault, alert, ready in bits 7, 6, 4.
// - Phase status is read-only with bits 5, 4, 3 set while phases 4, 3, 2 are enabled.
// - Phase status bit 2 is one while the active-low power-save input is asserted.
`timescale 1ns/1ps
`default_nettype none
module mask_status_regs
  import mask_status_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic vout_flag,
  input wire logic iout_flag,
  input wire logic comm_flag,
  input wire logic monitor_input_level_flag,
  input wire logic output_power_flag,
  input wire logic ready,
  input wire logic phase4_en,
  input wire logic phase3_en,
  input wire logic phase2_en,
  input wire logic power_save_request_n,
  output logic fault_ind,
  output logic alert_ind
);

  mask_combine_if mc();

  logic scl_meta_ff, scl_sync_ff, scl_prev_ff;
  logic sda_meta_ff, sda_sync_ff, sda_prev_ff;
  logic save_meta_ff, save_sync_ff;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  link_state_type state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [7:0] cmd_ff;
  logic rw_ff;
  logic nack_ff;
  logic sda_oe_n_ff;
  logic sda_o_ff;
  logic [7:0] alert_mask_ff;
  logic [7:0] fault_mask_ff;
  logic [7:0] gen_status_ff;
  logic [7:0] phase_status_ff;
  logic [7:0] rd_data;
  logic [7:0] nxt_gen_status;
  logic [7:0] nxt_phase_status;
  logic wr_commit;

  // Pins pass two flops before anything looks at them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta_ff <= 1'b1;
      scl_sync_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_meta_ff <= scl_i;
      scl_sync_ff <= scl_meta_ff;
      scl_prev_ff <= scl_sync_ff;
      sda_meta_ff <= sda_i;
      sda_sync_ff <= sda_meta_ff;
      sda_prev_ff <= sda_sync_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      save_meta_ff <= 1'b1;
      save_sync_ff <= 1'b1;
    end else begin
      save_meta_ff <= power_save_request_n;
      save_sync_ff <= save_meta_ff;
    end
  end

  assign scl_rise = scl_sync_ff & ~scl_prev_ff;
  assign scl_fall = ~scl_sync_ff & scl_prev_ff;
  assign start_seen = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
  assign stop_seen = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;

  always_comb begin
    case (cmd_ff)
      ALERT_MASK_OFS: rd_data = alert_mask_ff;
      FAULT_MASK_OFS: rd_data = fault_mask_ff;
      GEN_STATUS_OFS: rd_data = gen_status_ff;
      PHASE_STATUS_OFS: rd_data = phase_status_ff;
      default: rd_data = UNMAPPED_RD;
    endcase
  end

  // Transfer engine; data pin changes only while the clock line is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'hFF;
      cmd_ff <= 8'h00;
      rw_ff <= 1'b0;
      nack_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
    end else if (start_seen) begin
      state_ff <= ST_ADDR;
      bit_cnt_ff <= 4'h0;
      sda_oe_n_ff <= 1'b1;
    end else if (stop_seen) begin
      state_ff <= ST_IDLE;
      sda_oe_n_ff <= 1'b1;
    end else if (scl_rise) begin
      case (state_ff)
        ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA: begin
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
          shift_ff <= {shift_ff[6:0], sda_sync_ff};
        end
        ST_RDATA_ACK: nack_ff <= sda_sync_ff;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_ff)
        ST_ADDR: begin
          if (bit_cnt_ff == BITS_PER_BYTE) begin
            if (shift_ff[7:1] == DEV_ADDR) begin
              sda_oe_n_ff <= 1'b0;
              rw_ff <= shift_ff[0];
              state_ff <= ST_ADDR_ACK;
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          bit_cnt_ff <= 4'h0;
          if (rw_ff) begin
            sda_oe_n_ff <= rd_data[7];
            tx_ff <= {rd_data[6:0], 1'b1};
            state_ff <= ST_RDATA;
          end else begin
            sda_oe_n_ff <= 1'b1;
            state_ff <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (bit_cnt_ff == BITS_PER_BYTE) begin
            cmd_ff <= shift_ff;
            sda_oe_n_ff <= 1'b0;
            state_ff <= ST_CMD_ACK;
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK: begin
          sda_oe_n_ff <= 1'b1;
          bit_cnt_ff <= 4'h0;
          state_ff <= ST_WDATA;
        end
        ST_WDATA: begin
          if (bit_cnt_ff == BITS_PER_BYTE) begin
            sda_oe_n_ff <= 1'b0;
            state_ff <= ST_WDATA_ACK;
          end
        end
        ST_RDATA: begin
          if (bit_cnt_ff == BITS_PER_BYTE) begin
            sda_oe_n_ff <= 1'b1;
            state_ff <= ST_RDATA_ACK;
          end else begin
            sda_oe_n_ff <= tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b1};
          end
        end
        ST_RDATA_ACK: begin
          bit_cnt_ff <= 4'h0;
          if (!nack_ff) begin
            sda_oe_n_ff <= rd_data[7];
            tx_ff <= {rd_data[6:0], 1'b1};
            state_ff <= ST_RDATA;
          end else begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Open drain: the line is only ever pulled low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_o_ff <= 1'b0;
    end else begin
      sda_o_ff <= 1'b0;
    end
  end

  assign wr_commit = scl_fall && !start_seen && !stop_seen && !scl_rise &&
                     (state_ff == ST_WDATA) && (bit_cnt_ff == BITS_PER_BYTE);

  // Writes to status offsets are acknowledged but dropped, keeping them read-only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_mask_ff <= ALERT_MASK_RST;
      fault_mask_ff <= FAULT_MASK_RST;
    end else if (wr_commit) begin
      if (cmd_ff == ALERT_MASK_OFS) begin
        alert_mask_ff <= shift_ff;
      end
      if (cmd_ff == FAULT_MASK_OFS) begin
        fault_mask_ff <= shift_ff;
      end
    end
  end

  always_comb begin
    nxt_gen_status = GEN_STATUS_RST;
    nxt_gen_status[GS_FAULT_BIT] = mc.fault;
    nxt_gen_status[GS_ALERT_BIT] = mc.alert;
    nxt_gen_status[GS_READY_BIT] = ready;
    nxt_phase_status = PHASE_STATUS_RST;
    nxt_phase_status[PS_PHASE4_BIT] = phase4_en;
    nxt_phase_status[PS_PHASE3_BIT] = phase3_en;
    nxt_phase_status[PS_PHASE2_BIT] = phase2_en;
    nxt_phase_status[PS_SAVE_BIT] = ~save_sync_ff;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_status_ff <= GEN_STATUS_RST;
      phase_status_ff <= PHASE_STATUS_RST;
    end else begin
      gen_status_ff <= nxt_gen_status;
      phase_status_ff <= nxt_phase_status;
    end
  end

  always_comb begin
    mc.src = 8'h00;
    mc.src[VOUT_BIT] = vout_flag;
    mc.src[IOUT_BIT] = iout_flag;
    mc.src[COMM_BIT] = comm_flag;
    mc.src[MON_BIT] = monitor_input_level_flag;
    mc.src[PWR_BIT] = output_power_flag;
  end
  assign mc.alert_mask = alert_mask_ff;
  assign mc.fault_mask = fault_mask_ff;

  mask_combine u_combine (
    .clk(clk),
    .rst_n(rst_n),
    .mc(mc)
  );

  assign sda_o = sda_o_ff;
  assign sda_oe_n = sda_oe_n_ff;
  assign fault_ind = mc.fault;
  assign alert_ind = mc.alert;

  fault_mask_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    !$stable(fault_mask_ff) |-> $past(wr_commit && cmd_ff == FAULT_MASK_OFS))
    else $error("fault mask changed without a write");
  gen_status_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> gen_status_ff == {$past(mc.fault), $past(mc.alert), 1'b0, $past(ready), 4'h0})
    else $error("general status does not track fault, alert, ready");
  phase_status_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n |=> phase_status_ff[5:3] == {$past(phase4_en), $past(phase3_en), $past(phase2_en)})
    else $error("phase status does not track phase enables");
  save_status_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(power_save_request_n) |-> ##3 phase_status_ff[PS_SAVE_BIT])
    else $error("power-save status not set three cycles after request");
  save_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(power_save_request_n) |-> ##3 !phase_status_ff[PS_SAVE_BIT])
    else $error("power-save status not cleared three cycles after release");
  alert_mask_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    !$stable(alert_mask_ff) |-> $past(wr_commit && cmd_ff == ALERT_MASK_OFS))
    else $error("alert mask changed without a write");
  alert_raise_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && (|(mc.src & ~mc.alert_mask & SRC_USED))) |=> alert_ind)
    else $error("unmasked source did not raise alert");

  write_commit_c: cover property (@(posedge clk) disable iff (!rst_n)
    wr_commit && cmd_ff == FAULT_MASK_OFS);
  read_byte_c: cover property (@(posedge clk) disable iff (!rst_n)
    state_ff == ST_RDATA_ACK && scl_fall);
  save_request_c: cover property (@(posedge clk) disable iff (!rst_n)
    phase_status_ff[PS_SAVE_BIT]);

endmodule
`default_nettype wire

// >>> bus_host.sv
// Behavioural management-bus host that pulls the clock and data lines.
// Assumes pull-ups on both lines; the bench resolves the data wire for everyone.
`timescale 1ns/1ps
`default_nettype none
module bus_host
  import mask_status_pkg::*;
(
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Five clocks per phase so the slave's synchroniser sees every edge
  task automatic put_bit(input logic b, output logic seen);
    sda_pull <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(5);
    seen = sda;
    scl <= 1'b0;
    tick(1);
  endtask
  // Data released before the clock rises, so no false stop is seen
  task automatic start_cond();
    sda_pull <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(5);
    sda_pull <= 1'b1;
    tick(5);
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic stop_cond();
    sda_pull <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(5);
    sda_pull <= 1'b0;
    tick(5);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  // Ends with a not-acknowledge so the slave stops re-sending
  task automatic get_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(1'b1, s);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d,
                           output logic ack);
    logic a0, a1, a2;
    start_cond();
    put_byte({dev, 1'b0}, a0);
    put_byte(ofs, a1);
    put_byte(d, a2);
    stop_cond();
    ack = a0 & a1 & a2;
  endtask
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d, output logic ack);
    logic a0, a1, a2;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, a0);
    put_byte(ofs, a1);
    start_cond();
    put_byte({DEV_ADDR, 1'b1}, a2);
    get_byte(d);
    stop_cond();
    ack = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

// >>> alert_fault_mask_status_regs_bench.sv
// Self-checking bench for the mask and status register bank.
// Assumes the bus host model drives the pins; flags are driven here.
`timescale 1ns/1ps
`default_nettype none
module alert_fault_mask_status_regs_bench
  import mask_status_pkg::*;
;
  localparam int LIMIT = 40000;
  logic clk, rst_n, scl, sda_pull, sda_o, sda_oe_n, ready, psr_n, fault_ind, alert_ind, ack;
  wire logic sda;
  logic [7:0] cat, got;
  logic [2:0] ph;
  int n_mismatch, n_compared, cycles;
  assign sda = ~sda_pull & (sda_oe_n | sda_o);
  bus_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  mask_status_regs i_mask_status_regs (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .vout_flag(cat[VOUT_BIT]), .iout_flag(cat[IOUT_BIT]),
    .comm_flag(cat[COMM_BIT]), .monitor_input_level_flag(cat[MON_BIT]),
    .output_power_flag(cat[PWR_BIT]), .ready(ready), .phase4_en(ph[2]), .phase3_en(ph[1]),
    .phase2_en(ph[0]), .power_save_request_n(psr_n), .fault_ind(fault_ind),
    .alert_ind(alert_ind));
  initial clk = 1'b0;
  always #50 clk = ~clk;
  task automatic end_of_test();
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic check_byte(input string name, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      n_mismatch++;
    end
  endtask
  task automatic check_bit(input string name, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %b seen %b", name, e, g);
      n_mismatch++;
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    i_host.write_reg(DEV_ADDR, ofs, d, ack);
    check_bit("write ack", 1'b1, ack);
  endtask
  task automatic rd(input logic [7:0] ofs, input logic [7:0] e);
    i_host.read_reg(ofs, got, ack);
    check_bit("read ack", 1'b1, ack);
    check_byte("read data", e, got);
  endtask
  task automatic test_reset();
    rd(ALERT_MASK_OFS, 8'h00);
    rd(FAULT_MASK_OFS, 8'h00);
    rd(GEN_STATUS_OFS, 8'h00);
    rd(PHASE_STATUS_OFS, 8'h00);
  endtask
  // Each category alone: unmasked, masked by its own bit, and all other bits set
  task automatic test_masks();
    int bits [5] = '{VOUT_BIT, IOUT_BIT, COMM_BIT, MON_BIT, PWR_BIT};
    logic [7:0] m [3];
    for (int c = 0; c < 5; c++) begin
      cat <= 8'h01 << bits[c];
      m[0] = 8'h00;
      m[1] = 8'h01 << bits[c];
      m[2] = ~m[1];
      for (int k = 0; k < 3; k++) begin
        wr(ALERT_MASK_OFS, m[k]);
        wr(FAULT_MASK_OFS, m[k]);
        rd(FAULT_MASK_OFS, m[k]);
        rd(ALERT_MASK_OFS, m[k]);
        repeat (3) @(posedge clk);
        check_bit("alert_ind", k != 1, alert_ind);
        check_bit("fault_ind", k != 1, fault_ind);
      end
    end
    wr(ALERT_MASK_OFS, 8'h00);
    wr(FAULT_MASK_OFS, 8'h00);
  endtask
  task automatic test_general();
    cat <= 8'h01 << VOUT_BIT;
    ready <= 1'b1;
    repeat (3) @(posedge clk);
    rd(GEN_STATUS_OFS, 8'hD0);
    wr(GEN_STATUS_OFS, 8'h00);
    rd(GEN_STATUS_OFS, 8'hD0);
    cat <= 8'h00;
    ready <= 1'b0;
    repeat (3) @(posedge clk);
    rd(GEN_STATUS_OFS, 8'h00);
  endtask
  task automatic test_phase();
    ph <= 3'b101;
    psr_n <= 1'b0;
    repeat (5) @(posedge clk);
    rd(PHASE_STATUS_OFS, 8'h2C);
    wr(PHASE_STATUS_OFS, 8'hFF);
    rd(PHASE_STATUS_OFS, 8'h2C);
    ph <= 3'b010;
    psr_n <= 1'b1;
    repeat (5) @(posedge clk);
    rd(PHASE_STATUS_OFS, 8'h10);
  endtask
  // Foreign address is not acknowledged; unmapped command reads zero
  task automatic test_refused();
    i_host.write_reg(7'h21, FAULT_MASK_OFS, 8'hFF, ack);
    check_bit("foreign ack", 1'b0, ack);
    rd(FAULT_MASK_OFS, 8'h00);
    rd(8'h10, UNMAPPED_RD);
  endtask
  // Reset in mid-run returns both masks to zero
  task automatic test_midrun_reset();
    wr(ALERT_MASK_OFS, 8'h3A);
    wr(FAULT_MASK_OFS, 8'hC5);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ALERT_MASK_OFS, 8'h00);
    rd(FAULT_MASK_OFS, 8'h00);
  endtask
  initial begin
    rst_n = 1'b0;
    cat = 8'h00;
    ready = 1'b0;
    ph = 3'b000;
    psr_n = 1'b1;
    n_mismatch = 0;
    n_compared = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    test_reset();
    test_masks();
    test_general();
    test_phase();
    test_refused();
    test_midrun_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
